// ==== verilog/smc_motion.sv ====
// Motion command decoder, pulse generator and status readback
//
// How it works
// R1: Ramped move takes three count bytes, then ramps with init parameters.
// R2: Count below twice ramp count gives a triangle, no plateau.
// R3: Ramped move: decel limits slow, stop limits stop; far side ignored.
// R4: Count field is steps minus one; all ones means 16,777,216 steps.
// R5: Data bytes arrive least significant first and assemble that way.
// R6: Constant move takes a rate byte then three count bytes, no ramp.
// R7: Constant move stops on side limits; remaining count and cause kept.
// R8: Constant-to-limit has no data, runs to same-side stop limit only.
// R9: Fast-to-limit ramps up, decelerates over ramp count on limit.
// R10: Deceleration in fast-to-limit continues after the limit releases.
// R11: Base-point move ends on base input, relevant limit or stop.
// R12: Read command only at standstill; selects one of four readbacks.
// R13: Finish status low three bits hold the finished operation code.
// R14: Finish bits 3 and 4 flag decel-limit and stop-limit stops.
// R15: Finish bit 5 flags a start refused by motor-on low.
// R16: Finish bit 6 flags an emergency or decelerating stop.
// R17: A move ending by pulse exhaustion clears finish bits 3 to 6.
// R18: Active-low interrupt at end unless masked; finish read clears it.
// R19: Input snapshot holds input levels at the moment of stop.
// R20: Phase snapshot shows current phase outputs in bits 3 to 7.
// R21: Remaining count readable after limit or command stop, for resume.
// R22: Remaining count reads zero after normal completion.
// R23: Step rate is basic clock over rate value; clock source selectable.
// R24: Host writes only when buffer flag clear and not busy.
module smc_motion
  import smc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd,
  input wire smc_init_t i_init,
  input wire smc_pins_t i_pins,
  input wire logic i_emerg_stop,
  input wire logic i_decel_stop,
  input wire logic i_int_mask,
  output logic o_input_buffer_full_flag,
  output logic o_busy,
  output logic [7:0] o_rd_data,
  output logic o_int_n,
  output logic o_step,
  output logic o_dir,
  output logic [4:0] o_phase
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  smc_pins_t meta_reg, sync_reg;
  genvar gi;
  generate
    for (gi = 0; gi < $bits(smc_pins_t); gi++) begin : g_sync
      // Left unreset so the pins are settled when reset releases
      always_ff @(posedge i_sys_clk) begin
        meta_reg[gi] <= i_pins[gi];
        sync_reg[gi] <= meta_reg[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  smc_state_t state_reg;
  logic [2:0] mode_reg;
  logic dir_reg, ext_prev_reg, decel_reg, dcause_reg, ibf_reg;
  logic [1:0] idx_reg, rd_sel_reg, rd_idx_reg;
  logic [7:0] rate_reg, cur_ra_reg, tick_reg, fin_reg, insnap_reg;
  logic [23:0] data_reg;
  logic [24:0] remain_reg;
  logic [15:0] accel_reg, dleft_reg;
  logic [11:0] div_reg;

  logic wr_ok, is_rd_cmd, is_op_cmd, last_byte, start, base_tick, fire;
  logic stop_lim, dcl_lim, counted, ramped, end_now;
  logic [1:0] need_bytes;
  logic [7:0] eff_ra, fin_next;

  assign wr_ok = i_wr && !ibf_reg;
  assign is_op_cmd = i_wr_data[7:CMD_CLASS_POS] == CMD_CLASS_OP;
  assign is_rd_cmd = i_wr_data[7:CMD_CLASS_POS] == CMD_CLASS_RD;
  // Only the limits on the side of travel count [R3]
  assign stop_lim = dir_reg ? !sync_reg.stop_limit_ccw_n
                            : !sync_reg.stop_limit_cw_n;
  assign dcl_lim = dir_reg ? !sync_reg.decel_limit_ccw_n
                           : !sync_reg.decel_limit_cw_n;
  assign counted = mode_reg == OP_RAMP || mode_reg == OP_CONST;
  assign ramped = mode_reg == OP_RAMP || mode_reg == OP_FAST_LIM;

  always_comb begin
    case (i_wr_data[2:0])
      OP_RAMP: need_bytes = 2'd3; // [R1]
      OP_CONST: need_bytes = 2'd0; // [R6]
      default: need_bytes = 2'd0; // [R8]
    endcase
  end
  // Constant move needs four bytes, held as a wrap of the 2-bit index
  assign last_byte = (mode_reg == OP_CONST) ? idx_reg == 2'd3
                                            : idx_reg == 2'd2;
  assign start = (state_reg == ST_IDLE && wr_ok && is_op_cmd &&
                  i_wr_data[2:0] >= OP_RAMP &&
                  need_bytes == 2'd0 && i_wr_data[2:0] != OP_CONST) ||
                 (state_reg == ST_DATA && wr_ok && last_byte);

  // ----------------------------------------------------------------
  // Basic clock and step timing
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      div_reg <= 12'h000;
      ext_prev_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == BASE_DIV_LAST) ? 12'h000 : div_reg + 12'h001;
      ext_prev_reg <= sync_reg.ext_clk;
    end
  end
  assign base_tick = i_init.ext_clk_sel ? (sync_reg.ext_clk && !ext_prev_reg)
                                        : div_reg == BASE_DIV_LAST; // [R23]
  assign eff_ra = (cur_ra_reg == 8'h00) ? 8'h01 : cur_ra_reg;
  // No step on the cycle that ends the move, so the count cannot wrap
  assign fire = state_reg == ST_RUN && base_tick && !end_now &&
                tick_reg + 8'h01 >= eff_ra; // [R23]
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || state_reg != ST_RUN || fire) begin
      tick_reg <= 8'h00;
    end else if (base_tick) begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // End of operation and finish code
  // ----------------------------------------------------------------
  always_comb begin
    end_now = 1'b1;
    fin_next = {4'h0, 1'b0, mode_reg};
    if (state_reg != ST_RUN) begin
      end_now = 1'b0;
    end else if (i_emerg_stop || (!ramped && i_decel_stop)) begin
      fin_next[FIN_CMD_BIT] = 1'b1; // [R16]
    end else if (stop_lim) begin
      fin_next[FIN_STP_BIT] = 1'b1; // [R14]
    end else if (dcl_lim &&
                 (mode_reg == OP_CONST || mode_reg == OP_BASE)) begin
      fin_next[FIN_DCL_BIT] = 1'b1; // [R7] [R11] [R14]
    end else if (mode_reg == OP_BASE && !sync_reg.base_point_input_n) begin
      fin_next = {5'h00, mode_reg}; // [R11]
    end else if (decel_reg && dleft_reg == 16'h0000) begin
      fin_next[dcause_reg ? FIN_CMD_BIT : FIN_DCL_BIT] = 1'b1; // [R10]
    end else if (counted && remain_reg == 25'h0) begin
      fin_next = {5'h00, mode_reg}; // [R17]
    end else begin
      end_now = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      mode_reg <= 3'h0;
      dir_reg <= 1'b0;
      idx_reg <= 2'h0;
      rate_reg <= 8'h00;
      data_reg <= 24'h000000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= 2'h0;
          if (wr_ok && is_op_cmd && i_wr_data[2:0] >= OP_RAMP) begin
            mode_reg <= i_wr_data[2:0];
            dir_reg <= i_wr_data[CMD_DIR_POS];
            if (i_wr_data[2:0] == OP_RAMP || i_wr_data[2:0] == OP_CONST) begin
              state_reg <= ST_DATA;
            end else if (sync_reg.motor_on_input) begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_DATA: begin
          if (wr_ok) begin
            idx_reg <= idx_reg + 2'h1;
            if (mode_reg == OP_CONST && idx_reg == 2'h0) begin
              rate_reg <= i_wr_data; // [R6]
            end else begin
              case (mode_reg == OP_CONST ? idx_reg - 2'h1 : idx_reg)
                2'h0: data_reg[7:0] <= i_wr_data; // [R5]
                2'h1: data_reg[15:8] <= i_wr_data; // [R5]
                default: data_reg[23:16] <= i_wr_data; // [R5]
              endcase
            end
            if (last_byte) begin
              state_reg <= sync_reg.motor_on_input ? ST_RUN : ST_IDLE;
            end
          end
        end
        ST_RUN: begin
          if (end_now) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pulse count, ramp and phase stepping
  // ----------------------------------------------------------------
  logic [2:0] start_op;
  logic start_ramped;
  assign start_op = (state_reg == ST_IDLE) ? i_wr_data[2:0] : mode_reg;
  assign start_ramped = start_op == OP_RAMP || start_op == OP_FAST_LIM;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      remain_reg <= 25'h0;
      cur_ra_reg <= 8'h00;
      accel_reg <= 16'h0000;
      dleft_reg <= 16'h0000;
      decel_reg <= 1'b0;
      dcause_reg <= 1'b0;
      o_phase <= PHASE_RESET;
    end else if (state_reg != ST_RUN) begin
      accel_reg <= 16'h0000;
      decel_reg <= 1'b0;
      dcause_reg <= 1'b0;
      if (start) begin
        if (state_reg == ST_DATA) begin
          // The last data byte is the top byte of the count
          remain_reg <= {1'b0, i_wr_data, data_reg[15:0]} + 25'h1; // [R4]
        end
        // From idle the mode register only loads on this edge
        cur_ra_reg <= start_ramped ? i_init.ra_max
                    : (start_op == OP_CONST ? rate_reg : i_init.cra);
      end
    end else begin
      // Sticky: the limit releasing does not abort deceleration
      if (ramped && !decel_reg && (dcl_lim || i_decel_stop)) begin
        decel_reg <= 1'b1; // [R3] [R9] [R10]
        dcause_reg <= !dcl_lim;
        dleft_reg <= (mode_reg == OP_FAST_LIM) ? i_init.ramp_cnt
                                               : accel_reg; // [R9]
      end
      if (fire) begin
        o_phase <= {1'b0, dir_reg ? {o_phase[0], o_phase[3:1]}
                                  : {o_phase[2:0], o_phase[3]}};
        if (counted) begin
          remain_reg <= remain_reg - 25'h1; // [R1] [R6]
        end
        if (ramped) begin
          if (decel_reg || (counted && remain_reg[15:0] <= accel_reg &&
                            remain_reg[24:16] == 9'h0)) begin
            // Triangle falls out: decel starts once the rest fits [R2]
            if (cur_ra_reg < i_init.ra_max) begin
              cur_ra_reg <= cur_ra_reg + 8'h01;
            end
            if (decel_reg && dleft_reg != 16'h0000) begin
              dleft_reg <= dleft_reg - 16'h0001;
            end
          end else if (cur_ra_reg > i_init.ra_min &&
                       accel_reg < i_init.ramp_cnt) begin
            cur_ra_reg <= cur_ra_reg - 8'h01; // [R1] [R9]
            accel_reg <= accel_reg + 16'h0001;
          end
        end
      end
      if (end_now && !counted) begin
        remain_reg <= 25'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Finish status, snapshots and interrupt
  // ----------------------------------------------------------------
  logic fin_evt, mon_fail, fin_read;
  assign mon_fail = (state_reg == ST_IDLE && wr_ok && is_op_cmd &&
                     i_wr_data[2:0] >= OP_FAST_LIM - 3'h1 &&
                     i_wr_data[2:0] != OP_CONST &&
                     !sync_reg.motor_on_input) ||
                    (state_reg == ST_DATA && wr_ok && last_byte &&
                     !sync_reg.motor_on_input);
  assign fin_evt = end_now || mon_fail;
  assign fin_read = i_rd && rd_sel_reg == RD_FINISH;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fin_reg <= FIN_RESET;
      insnap_reg <= INSNAP_RESET;
      o_int_n <= 1'b1;
    end else begin
      if (end_now) begin
        fin_reg <= fin_next; // [R13] [R14] [R16] [R17]
        insnap_reg <= {2'b00, sync_reg[5:0]}; // [R19]
      end else if (mon_fail) begin
        fin_reg <= {2'b00, 1'b1, 2'b00,
                    state_reg == ST_DATA ? mode_reg : i_wr_data[2:0]}; // [R15]
      end
      // A new finish beats a simultaneous status read
      if (fin_evt && !i_int_mask) begin
        o_int_n <= 1'b0; // [R18]
      end else if (fin_read) begin
        o_int_n <= 1'b1; // [R18]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read register command and readback
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_sel_reg <= RD_FINISH;
      rd_idx_reg <= 2'h0;
      o_rd_data <= 8'h00;
      ibf_reg <= 1'b0;
    end else begin
      ibf_reg <= i_wr && !ibf_reg;
      if (state_reg == ST_IDLE && wr_ok && is_rd_cmd) begin
        rd_sel_reg <= i_wr_data[1:0]; // [R12]
        rd_idx_reg <= 2'h0;
      end else if (i_rd && rd_idx_reg != 2'h3) begin
        rd_idx_reg <= rd_idx_reg + 2'h1;
      end
      case (rd_sel_reg)
        RD_FINISH: o_rd_data <= fin_reg;
        RD_INPUTS: o_rd_data <= insnap_reg;
        RD_PHASE: o_rd_data <= {o_phase, 3'b000}; // [R20]
        default: o_rd_data <= (rd_idx_reg == 2'h0) ? remain_reg[7:0]
                            : (rd_idx_reg == 2'h1) ? remain_reg[15:8]
                            : remain_reg[23:16]; // [R21] [R22]
      endcase
    end
  end

  assign o_input_buffer_full_flag = ibf_reg; // [R24]
  assign o_busy = state_reg == ST_RUN;
  assign o_step = fire;
  assign o_dir = dir_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_int_on_fin;
    @(posedge i_sys_clk) disable iff (i_reset)
      fin_evt && !i_int_mask |=> !o_int_n;
  endproperty
  a_int_on_fin: assert property (p_int_on_fin) // [R18]
    else $error("interrupt missing at finish");
  property p_int_clear;
    @(posedge i_sys_clk) disable iff (i_reset)
      fin_read && !fin_evt ##1 !fin_evt |=> o_int_n;
  endproperty
  a_int_clear: assert property (p_int_clear) // [R18]
    else $error("interrupt not released by status read");
  property p_stop_lim;
    @(posedge i_sys_clk) disable iff (i_reset)
      state_reg == ST_RUN && stop_lim && !i_emerg_stop && !i_decel_stop
      |=> state_reg == ST_IDLE && fin_reg[FIN_STP_BIT];
  endproperty
  a_stop_lim: assert property (p_stop_lim) // [R14]
    else $error("stop limit did not stop the move");
  property p_cnt_end;
    @(posedge i_sys_clk) disable iff (i_reset)
      end_now && fin_next[6:3] == 4'h0 && counted
      |=> fin_reg[6:3] == 4'h0 ##1 o_rd_data == 8'h00 || rd_sel_reg != 2'h3;
  endproperty
  a_cnt_end: assert property (p_cnt_end) // [R17]
    else $error("normal end left cause bits or count");
  property p_mon;
    @(posedge i_sys_clk) disable iff (i_reset)
      mon_fail && !end_now |=> fin_reg[FIN_MON_BIT] && state_reg == ST_IDLE;
  endproperty
  a_mon: assert property (p_mon) // [R15]
    else $error("motor-on refusal not flagged");
  property p_rd_idle;
    @(posedge i_sys_clk) disable iff (i_reset)
      state_reg == ST_RUN |=> $stable(rd_sel_reg);
  endproperty
  a_rd_idle: assert property (p_rd_idle) // [R12]
    else $error("read command taken while moving");
  property p_limit_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
      state_reg == ST_RUN && mode_reg == OP_CONST_LIM && !stop_lim &&
      !i_emerg_stop && !i_decel_stop |=> state_reg == ST_RUN;
  endproperty
  a_limit_hold: assert property (p_limit_hold) // [R8]
    else $error("constant-to-limit ended without its limit");
  property p_decel_sticky;
    @(posedge i_sys_clk) disable iff (i_reset)
      state_reg == ST_RUN && decel_reg |=> decel_reg || state_reg == ST_IDLE;
  endproperty
  a_decel_sticky: assert property (p_decel_sticky) // [R10]
    else $error("deceleration abandoned");
endmodule

// ==== verilog/smc_pkg.sv ====
// Shared constants and carriers of the stepper motion command unit
package smc_pkg;
  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_CLASS_OP = 2'h1;
  localparam logic [1:0] CMD_CLASS_RD = 2'h2;
  localparam int CMD_CLASS_POS = 6;
  localparam int CMD_DIR_POS = 5;
  localparam logic [2:0] OP_RAMP = 3'h3;
  localparam logic [2:0] OP_CONST = 3'h4;
  localparam logic [2:0] OP_CONST_LIM = 3'h5;
  localparam logic [2:0] OP_FAST_LIM = 3'h6;
  localparam logic [2:0] OP_BASE = 3'h7;
  // ----------------------------------------------------------------
  // Readback selections and finish status fields
  // ----------------------------------------------------------------
  localparam logic [1:0] RD_FINISH = 2'h0;
  localparam logic [1:0] RD_INPUTS = 2'h1;
  localparam logic [1:0] RD_PHASE = 2'h2;
  localparam logic [1:0] RD_REMAIN = 2'h3;
  localparam int FIN_DCL_BIT = 3;
  localparam int FIN_STP_BIT = 4;
  localparam int FIN_MON_BIT = 5;
  localparam int FIN_CMD_BIT = 6;
  localparam logic [7:0] FIN_RESET = 8'h00;
  localparam logic [7:0] INSNAP_RESET = 8'h00;
  localparam logic [4:0] PHASE_RESET = 5'h03;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int INT_BASE_HZ = 12_500;
  localparam int BASE_DIV_CYC = SYS_CLK_HZ / INT_BASE_HZ;
  localparam logic [11:0] BASE_DIV_LAST = 12'(BASE_DIV_CYC - 1);
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ramp_cnt;
    logic [7:0] cra;
    logic [7:0] ra_max;
    logic [7:0] ra_min;
    logic ext_clk_sel;
  } smc_init_t;
  typedef struct packed {
    logic ext_clk;
    logic base_point_input_n;
    logic motor_on_input;
    logic decel_limit_ccw_n;
    logic decel_limit_cw_n;
    logic stop_limit_ccw_n;
    logic stop_limit_cw_n;
  } smc_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_RUN = 3'b100
  } smc_state_t;
endpackage

// ==== tb/smc_host.sv ====
// Host model that writes command bytes and reads status back
module smc_host
  import smc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_ibf,
  input wire logic i_busy,
  input wire logic [7:0] i_rd_data,
  output logic o_wr,
  output logic [7:0] o_wr_data,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  int timeouts = 0;
  initial begin
    o_wr = 1'b0;
    o_wr_data = 8'h00;
    o_rd = 1'b0;
  end
  // One byte per write; bounded wait on the buffer flag
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (i_ibf !== 1'b0 && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n == 100) timeouts++;
    @(negedge i_sys_clk);
    o_wr = 1'b1;
    o_wr_data = b;
    @(negedge i_sys_clk);
    o_wr = 1'b0;
    // Released data never repeats the last byte
    o_wr_data = ~b;
    @(negedge i_sys_clk);
  endtask
  task automatic move(input logic [2:0] op, input logic dir,
                      input logic [7:0] rate, input logic [23:0] cnt);
    int n;
    n = 0;
    while (i_busy !== 1'b0 && n < 30000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n == 30000) timeouts++;
    put({CMD_CLASS_OP, dir, 2'b00, op});
    if (op == OP_CONST) put(rate);
    if (op == OP_RAMP || op == OP_CONST) begin
      put(cnt[7:0]);
      put(cnt[15:8]);
      put(cnt[23:16]);
    end
  endtask
  // Finish read also releases the interrupt; remaining takes 3 bytes
  task automatic rdreg(input logic [1:0] sel, output logic [23:0] v);
    put({CMD_CLASS_RD, 4'h0, sel});
    @(negedge i_sys_clk);
    v = 24'h000000;
    for (int i = 0; i < 3; i++) begin
      if (i == 0 || sel == RD_REMAIN) begin
        v[8*i +: 8] = i_rd_data;
        if (sel == RD_FINISH || (sel == RD_REMAIN && i < 2)) begin
          o_rd = 1'b1;
          @(negedge i_sys_clk);
          o_rd = 1'b0;
          repeat (2) @(negedge i_sys_clk);
        end
      end
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the motion command unit
module tb
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EXT_HALF = 80;
  logic i_sys_clk, i_reset, i_wr, i_rd, i_emerg_stop, i_decel_stop;
  logic i_int_mask, o_input_buffer_full_flag, o_busy, o_int_n;
  logic o_step, o_dir;
  logic [7:0] i_wr_data, o_rd_data;
  logic [4:0] o_phase;
  logic [23:0] v;
  smc_init_t i_init;
  smc_pins_t i_pins;
  int err_total = 0;
  int total_checks = 0;
  int steps = 0;
  int k;
  time last_t = 0;
  time gap = 0;
  smc_motion dut(.i_sys_clk, .i_reset, .i_wr, .i_wr_data, .i_rd,
    .i_init, .i_pins, .i_emerg_stop, .i_decel_stop, .i_int_mask,
    .o_input_buffer_full_flag, .o_busy, .o_rd_data, .o_int_n, .o_step,
    .o_dir, .o_phase);
  smc_host host(.i_sys_clk, .i_ibf(o_input_buffer_full_flag),
    .i_busy(o_busy), .i_rd_data(o_rd_data), .o_wr(i_wr),
    .o_wr_data(i_wr_data), .o_rd(i_rd));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Fast external basic clock keeps step gaps short
  initial begin
    i_pins.ext_clk = 1'b0;
    #3;
    forever #EXT_HALF i_pins.ext_clk = ~i_pins.ext_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_step === 1'b1) begin
      steps <= steps + 1;
      gap <= $time - last_t;
      last_t <= $time;
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic [2:0] op, input logic dir,
                    input logic [7:0] rate, input logic [23:0] cnt);
    steps = 0;
    host.move(op, dir, rate, cnt);
  endtask
  task automatic wait_steps(input int n);
    int c;
    c = 0;
    while (steps < n && c < 20000) begin
      @(negedge i_sys_clk);
      c++;
    end
    if (c == 20000) begin
      err_total++;
      $display("[FAIL] steps expected %0d seen %0d", n, steps);
    end
  endtask
  task automatic wait_idle();
    int c;
    c = 0;
    repeat (3) @(negedge i_sys_clk);
    while (o_busy !== 1'b0 && c < 20000) begin
      @(negedge i_sys_clk);
      c++;
    end
    if (c == 20000) begin
      err_total++;
      $display("[FAIL] busy expected 0 seen 1");
    end
  endtask
  task automatic status(input logic [7:0] fin, input logic [7:0] m,
                        input logic [23:0] rem);
    check("int_n", {23'h0, o_int_n}, 24'h0);
    host.rdreg(RD_FINISH, v);
    check("finish", v & {16'h0, m}, {16'h0, fin & m});
    check("int_n clr", {23'h0, o_int_n}, 24'h1);
    host.rdreg(RD_REMAIN, v);
    check("remaining", v, rem);
    i_pins[5:0] = 6'h3f;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_const();
    host.rdreg(RD_PHASE, v);
    check("phase", v, {16'h0, PHASE_RESET, 3'h0});
    go(OP_CONST, 1'b0, 8'h03, 24'h000004);
    wait_idle();
    check("steps", 24'(steps), 24'h5);
    check("gap", 24'(gap), 24'(6 * EXT_HALF));
    check("phase pins", {19'h0, o_phase}, 24'h000006);
    host.rdreg(RD_PHASE, v);
    check("phase moved", v, 24'h000030);
    status(8'h04, 8'hff, 24'h0);
    go(OP_RAMP, 1'b1, 8'h00, 24'h000005);
    wait_idle();
    check("triangle", 24'(steps), 24'h6);
    status(8'h03, 8'hff, 24'h0);
    $display("test const and ramp done");
  endtask
  task automatic t_ramp_limit();
    i_pins.stop_limit_ccw_n = 1'b0;
    i_pins.decel_limit_ccw_n = 1'b0;
    go(OP_RAMP, 1'b0, 8'h00, 24'h00001d);
    wait_steps(12);
    i_pins.stop_limit_cw_n = 1'b0;
    wait_idle();
    host.rdreg(RD_INPUTS, v);
    check("inputs", v, 24'h000034);
    status(8'h13, 8'hff, 24'(30 - steps));
    go(OP_CONST, 1'b1, 8'h02, 24'h000013);
    wait_steps(5);
    check("dir", {23'h0, o_dir}, 24'h1);
    i_decel_stop = 1'b1;
    @(negedge i_sys_clk);
    i_decel_stop = 1'b0;
    wait_idle();
    status(8'h44, 8'hff, 24'(20 - steps));
    $display("test stops done");
  endtask
  task automatic t_limit_moves();
    i_pins.stop_limit_ccw_n = 1'b0;
    go(OP_CONST_LIM, 1'b0, 8'h00, 24'h0);
    wait_steps(6);
    i_pins.stop_limit_cw_n = 1'b0;
    wait_idle();
    status(8'h15, 8'hff, 24'h0);
    go(OP_FAST_LIM, 1'b0, 8'h00, 24'h0);
    wait_steps(8);
    i_pins.decel_limit_cw_n = 1'b0;
    repeat (10) @(negedge i_sys_clk);
    i_pins.decel_limit_cw_n = 1'b1;
    k = steps;
    wait_idle();
    check("decel run", 24'(steps > k), 24'h1);
    status(8'h0e, 8'hff, 24'h0);
    go(OP_BASE, 1'b0, 8'h00, 24'h0);
    wait_steps(4);
    i_pins.base_point_input_n = 1'b0;
    wait_idle();
    status(8'h07, 8'hff, 24'h0);
    go(OP_CONST_LIM, 1'b1, 8'h00, 24'h0);
    wait_steps(3);
    i_emerg_stop = 1'b1;
    @(negedge i_sys_clk);
    i_emerg_stop = 1'b0;
    wait_idle();
    status(8'h45, 8'hff, 24'h0);
    $display("test limit moves done");
  endtask
  task automatic t_motor_off();
    i_int_mask = 1'b1;
    i_pins.motor_on_input = 1'b0;
    // Let the pin clear its synchroniser before the command lands
    repeat (3) @(negedge i_sys_clk);
    go(OP_CONST_LIM, 1'b0, 8'h00, 24'h0);
    repeat (6) @(negedge i_sys_clk);
    check("busy", {23'h0, o_busy}, 24'h0);
    check("masked", {23'h0, o_int_n}, 24'h1);
    host.rdreg(RD_FINISH, v);
    check("finish", v, 24'h000025);
    i_int_mask = 1'b0;
    i_pins[5:0] = 6'h3f;
    $display("test motor off done");
  endtask
  task automatic summarize();
    check("host waits", 24'(host.timeouts), 24'h0);
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    $display("[FAIL] run expected done seen timeout");
    summarize();
  end
  initial begin
    i_reset = 1'b1;
    i_emerg_stop = 1'b0;
    i_decel_stop = 1'b0;
    i_int_mask = 1'b0;
    i_init = '{16'h0004, 8'h05, 8'h06, 8'h02, 1'b1};
    i_pins[5:0] = 6'h3f;
    repeat (20) @(negedge i_sys_clk);
    i_reset = 1'b0;
    t_const();
    t_ramp_limit();
    t_limit_moves();
    t_motor_off();
    summarize();
  end
endmodule
